// *** mrss_seq.sv ***
// Purpose: management reset, graceful shutdown and boot failover sequencer
// Assumes: all inputs synchronous to clk_sys; resetn is management power
// Notes:   reset outputs are pulses stretched to a fixed length
// Overview of operation
// - shutdown request raises power-button request
// - no sleep within 60 s forces off
// - boot watchdog expiry while bootRunning swaps boot flash
// - boot watchdog enabled from reset
// - unkicked firmware watchdog resets controller
// - firmware watchdog expiry also isolates management bus
// - cold reset restores power-up defaults except boot flash selection and, on firmware watchdog expiry, bus isolation
// - cold reset at power application
// - held in reset while power low
// - internal watchdog expiry cold resets controller
// - reset button five seconds: controller cold
// - short reset button press: payload cold
// - warm reset keeps preserved settings
// - payload power activation gives payload cold
// - boot watchdog expiry also payload cold
// - console network powered only handle closed
`timescale 1ns/1ps
module mrss_seq
  import mrss_pkg::*;
#(
  parameter longint unsigned SHUTDOWN_CYCLES  = SHUTDOWN_CYC,
  parameter longint unsigned LONGPRESS_CYCLES = LONGPRESS_CYC,
  parameter int unsigned     WDT_WIDTH        = WDT_W
) (
  // clock, reset and enable
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic                 clkEn,
  // shutdown sources and payload handshake
  input  wire logic                 handleOpen,
  input  wire logic                 shutdownCmd,
  input  wire logic                 payloadSleep,
  input  wire logic                 payloadPowerOn,
  output logic                      powerButtonReq,
  output logic                      forcePowerOff,
  // boot supervision
  input  wire logic                 bootRunning,
  input  wire logic                 bootWdogKick,
  input  wire logic                 bootWdogDisable,
  input  wire logic [WDT_WIDTH-1:0] bootWdogTimeout,
  output logic                      bootFlashSel,
  // firmware supervision
  input  wire logic                 fwWdogKick,
  input  wire logic [WDT_WIDTH-1:0] fwWdogTimeout,
  input  wire logic                 intWdogExpire,
  output logic                      mgmtBusIsolate,
  // reset sources and outputs
  input  wire logic                 resetButton,
  input  wire logic                 warmResetCmd,
  output mrss_rst_s                 rstOut,
  output logic                      consoleNetPower
);
  logic bootWdogExpire;
  logic fwWdogExpire;
  // controller cold request, also read by the isolation logic
  logic ctrlColdPend;

  mrss_wdog #(.W(WDT_WIDTH)) uBootWdog (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .clkEn   (clkEn),
    .enable  (!bootWdogDisable),
    .kick    (bootWdogKick),
    .timeout (bootWdogTimeout),
    .expire  (bootWdogExpire)
  );

  mrss_wdog #(.W(WDT_WIDTH)) uFwWdog (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .clkEn   (clkEn),
    .enable  (1'b1),
    .kick    (fwWdogKick),
    .timeout (fwWdogTimeout),
    .expire  (fwWdogExpire)
  );

  // graceful shutdown state
  mrss_sd_e         sdState;
  mrss_sd_e         next_sdState;
  logic [CNT_W-1:0] sdCount;
  logic [CNT_W-1:0] next_sdCount;
  logic             next_powerButtonReq;
  logic             next_forcePowerOff;
  logic             handleOpenQ;
  logic             next_handleOpenQ;

  always_comb begin
    next_sdState        = sdState;
    next_sdCount        = sdCount;
    next_powerButtonReq = powerButtonReq;
    next_forcePowerOff  = forcePowerOff;
    next_handleOpenQ    = handleOpen;
    unique case (sdState)
      MRSS_SD_IDLE: begin
        next_forcePowerOff = 1'b0;
        if ((handleOpen && !handleOpenQ) || shutdownCmd) begin
          next_powerButtonReq = 1'b1;
          next_sdCount        = '0;
          next_sdState        = MRSS_SD_WAIT;
        end
      end
      MRSS_SD_WAIT: begin
        if (payloadSleep) begin
          next_powerButtonReq = 1'b0;
          next_sdState        = MRSS_SD_IDLE;
        end else if (sdCount >= CNT_W'(SHUTDOWN_CYCLES - 1)) begin
          next_powerButtonReq = 1'b0;
          next_forcePowerOff  = 1'b1;
          next_sdState        = MRSS_SD_FORCE;
        end else begin
          next_sdCount = sdCount + CNT_W'(1);
        end
      end
      MRSS_SD_FORCE: begin
        // held off until the payload power is seen down
        if (!payloadPowerOn) begin
          next_forcePowerOff = 1'b0;
          next_sdState       = MRSS_SD_IDLE;
        end
      end
      default: begin
        next_sdState = MRSS_SD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sdState        <= MRSS_SD_IDLE;
      sdCount        <= '0;
      powerButtonReq <= 1'b0;
      forcePowerOff  <= 1'b0;
      handleOpenQ    <= 1'b0;
    end else if (clkEn) begin
      sdState        <= next_sdState;
      sdCount        <= next_sdCount;
      powerButtonReq <= next_powerButtonReq;
      forcePowerOff  <= next_forcePowerOff;
      handleOpenQ    <= next_handleOpenQ;
    end
  end

  // boot flash selection and bus isolation
  logic next_bootFlashSel;
  logic next_mgmtBusIsolate;

  always_comb begin
    next_bootFlashSel   = bootFlashSel;
    next_mgmtBusIsolate = mgmtBusIsolate;
    if (bootWdogExpire && bootRunning) begin
      next_bootFlashSel = !bootFlashSel;
    end
    if (fwWdogExpire) begin
      next_mgmtBusIsolate = 1'b1;
    end else if (ctrlColdPend) begin
      next_mgmtBusIsolate = 1'b0;
    end
  end

  // button timing and reset pulse generation
  logic [CNT_W-1:0] btnCount;
  logic [CNT_W-1:0] next_btnCount;
  logic             btnLong;
  logic             next_btnLong;
  logic             btnQ;
  logic             next_btnQ;
  logic             payloadPowerQ;
  logic             next_payloadPowerQ;
  logic             payloadColdPend;
  logic [4:0]       ctrlColdCnt;
  logic [4:0]       next_ctrlColdCnt;
  logic [4:0]       ctrlWarmCnt;
  logic [4:0]       next_ctrlWarmCnt;
  logic [4:0]       payColdCnt;
  logic [4:0]       next_payColdCnt;
  logic             powerUpDone;

  always_comb begin
    next_btnQ          = resetButton;
    next_payloadPowerQ = payloadPowerOn;
    next_btnCount      = btnCount;
    next_btnLong       = btnLong;
    ctrlColdPend       = 1'b0;
    payloadColdPend    = 1'b0;
    if (resetButton) begin
      if (btnCount >= CNT_W'(LONGPRESS_CYCLES - 1)) begin
        if (!btnLong) begin
          ctrlColdPend = 1'b1;
        end
        next_btnLong = 1'b1;
      end else begin
        next_btnCount = btnCount + CNT_W'(1);
      end
    end else begin
      next_btnCount = '0;
      next_btnLong  = 1'b0;
      if (btnQ && !btnLong) begin
        payloadColdPend = 1'b1;
      end
    end
    if (fwWdogExpire || intWdogExpire) begin
      ctrlColdPend = 1'b1;
    end
    if (!powerUpDone) begin
      ctrlColdPend = 1'b1;
    end
    if (payloadPowerOn && !payloadPowerQ) begin
      payloadColdPend = 1'b1;
    end
    if (bootWdogExpire) begin
      payloadColdPend = 1'b1;
    end
    next_ctrlColdCnt = ctrlColdPend ? 5'(RST_PULSE_CYC)
                     : (ctrlColdCnt != '0) ? ctrlColdCnt - 5'(1) : '0;
    next_ctrlWarmCnt = (warmResetCmd && !ctrlColdPend) ? 5'(RST_PULSE_CYC)
                     : (ctrlWarmCnt != '0) ? ctrlWarmCnt - 5'(1) : '0;
    next_payColdCnt  = payloadColdPend ? 5'(RST_PULSE_CYC)
                     : (payColdCnt != '0) ? payColdCnt - 5'(1) : '0;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      btnCount       <= '0;
      btnLong        <= 1'b0;
      btnQ           <= 1'b0;
      payloadPowerQ  <= 1'b0;
      ctrlColdCnt    <= '0;
      ctrlWarmCnt    <= '0;
      payColdCnt     <= '0;
      powerUpDone    <= 1'b0;
      mgmtBusIsolate <= 1'b0;
      bootFlashSel   <= BOOT_FLASH_RST;
    end else if (clkEn) begin
      btnCount       <= next_btnCount;
      btnLong        <= next_btnLong;
      btnQ           <= next_btnQ;
      payloadPowerQ  <= next_payloadPowerQ;
      ctrlColdCnt    <= next_ctrlColdCnt;
      ctrlWarmCnt    <= next_ctrlWarmCnt;
      payColdCnt     <= next_payColdCnt;
      powerUpDone    <= 1'b1;
      mgmtBusIsolate <= next_mgmtBusIsolate;
      // flash selection survives a warm reset
      bootFlashSel   <= next_bootFlashSel;
    end
  end

  // controller cold held during reset since resetn is the management power good
  always_comb begin
    // no gap between release and the power-up pulse
    rstOut.ctrlCold    = !resetn || !powerUpDone
                       || (ctrlColdCnt != '0);
    rstOut.ctrlWarm    = resetn && (ctrlWarmCnt != '0);
    rstOut.payloadCold = resetn && (payColdCnt != '0);
    consoleNetPower    = resetn && !handleOpen;
  end
endmodule // mrss_seq

// *** mrss_pkg.sv ***
// Purpose: shared constants and carriers for the reset and shutdown sequencer
// Assumes: clk_sys at 200 MHz
// Notes:   shutdown and long-press times kept in seconds, cycle counts derived from them; reset pulse length given in cycles
package mrss_pkg;
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned SHUTDOWN_SEC    = 60;
  localparam int unsigned LONGPRESS_SEC   = 5;
  localparam longint unsigned SHUTDOWN_CYC =
    longint'(SHUTDOWN_SEC) * longint'(CLK_HZ);
  localparam longint unsigned LONGPRESS_CYC =
    longint'(LONGPRESS_SEC) * longint'(CLK_HZ);
  localparam int unsigned CNT_W           = 40;
  localparam int unsigned WDT_W           = 32;
  localparam int unsigned RST_PULSE_CYC   = 16;
  localparam logic        BOOT_FLASH_RST  = 1'b0;

  typedef enum logic [1:0] {
    MRSS_SD_IDLE  = 2'b00,
    MRSS_SD_WAIT  = 2'b01,
    MRSS_SD_FORCE = 2'b10
  } mrss_sd_e;

  // reset requests produced by the sequencer
  typedef struct packed {
    logic ctrlCold;
    logic ctrlWarm;
    logic payloadCold;
  } mrss_rst_s;
endpackage

// *** mrss_wdog.sv ***
// Purpose: generic down-counting watchdog with restart and enable
// Assumes: synchronous inputs, single clock
// Notes:   expire is a one-cycle pulse; counter reloads on expiry
`timescale 1ns/1ps
module mrss_wdog
  import mrss_pkg::*;
#(
  parameter int unsigned W = WDT_W
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         clkEn,
  // control
  input  wire logic         enable,
  input  wire logic         kick,
  input  wire logic [W-1:0] timeout,
  // status
  output logic              expire
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         next_expire;

  always_comb begin
    next_count  = count;
    next_expire = 1'b0;
    if (!enable || kick) begin
      next_count = timeout;
    end else if (count == '0) begin
      next_expire = 1'b1;
      next_count  = timeout;
    end else begin
      next_count = count - W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count  <= '1;
      expire <= 1'b0;
    end else if (clkEn) begin
      count  <= next_count;
      expire <= next_expire;
    end
  end
endmodule // mrss_wdog

// *** mrss_seq_assertions.sv ***
// Purpose: port checks for the reset and shutdown sequencer
// Assumes: clkEn held high
// Notes:   power-up cold pulse checked over its first eight cycles
`timescale 1ns/1ps
module mrss_seq_checker
  import mrss_pkg::*;
#(
  parameter longint unsigned SHUTDOWN_CYCLES  = 100,
  parameter longint unsigned LONGPRESS_CYCLES = 20
) (
  // clock and reset
  input wire logic      clk_sys,
  input wire logic      resetn,
  // shutdown
  input wire logic      handleOpen,
  input wire logic      shutdownCmd,
  input wire logic      payloadSleep,
  input wire logic      powerButtonReq,
  input wire logic      forcePowerOff,
  input wire logic      consoleNetPower,
  // supervision and resets
  input wire logic      bootFlashSel,
  input wire logic      intWdogExpire,
  input wire logic      mgmtBusIsolate,
  input wire logic      resetButton,
  input wire mrss_rst_s rstOut
);
  logic [39:0] pressCnt;
  logic [39:0] next_pressCnt;
  // cycles the reset button has been held
  always_comb next_pressCnt = resetButton ? pressCnt + 40'h1 : 40'h0;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn) pressCnt <= 40'h0;
    else pressCnt <= next_pressCnt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_console_power: assert property (consoleNetPower == !handleOpen)
    else $error("console power wrong");
  a_reset_hold: assert property (disable iff (1'b0)
    !resetn |-> rstOut.ctrlCold && !powerButtonReq) else $error("reset hold");
  a_powerup_cold: assert property ($rose(resetn) |-> rstOut.ctrlCold [*8])
    else $error("no power-up cold reset");
  a_button_req: assert property ((shutdownCmd || $rose(handleOpen)) &&
    !powerButtonReq && !forcePowerOff && !payloadSleep |=> powerButtonReq)
    else $error("no power button request");
  a_sleep_cancel: assert property (powerButtonReq && payloadSleep |=>
    !powerButtonReq && !forcePowerOff) else $error("sleep not cancelling");
  a_force_off: assert property ($fell(powerButtonReq) &&
    !$past(payloadSleep) |-> forcePowerOff) else $error("no forced off");
  a_flash_swap: assert property ($changed(bootFlashSel) |->
    ##[0:2] rstOut.payloadCold) else $error("swap without payload reset");
  a_fw_isolate: assert property ($rose(mgmtBusIsolate) |->
    ##[0:2] rstOut.ctrlCold) else $error("isolation without cold reset");
  a_int_wdog: assert property (intWdogExpire |-> ##[1:2] rstOut.ctrlCold)
    else $error("internal expiry ignored");
  a_short_press: assert property ($fell(resetButton) &&
    pressCnt < LONGPRESS_CYCLES - 2 |-> ##[0:2] rstOut.payloadCold)
    else $error("short press ignored");
  a_long_press: assert property (pressCnt == LONGPRESS_CYCLES |->
    ##[0:6] rstOut.ctrlCold) else $error("long press ignored");
  cover property (forcePowerOff);
  cover property ($changed(bootFlashSel));
  cover property ($rose(mgmtBusIsolate));
endmodule // mrss_seq_checker

// *** mrss_payload_model.sv ***
// Purpose: behavioural payload answering the power button
// Assumes: sleepDelay of zero models an os that never sleeps
// Notes:   powerUp restores payload power and clears sleep
`timescale 1ns/1ps
module mrss_payload_model (
  // clock
  input wire logic       clk_sys,
  // from the sequencer
  input wire logic       powerButtonReq,
  input wire logic       forcePowerOff,
  // bench control
  input wire logic       powerUp,
  input wire logic [7:0] sleepDelay,
  // to the sequencer
  output logic           payloadSleep,
  output logic           payloadPowerOn
);
  logic [7:0] cnt;
  initial begin
    payloadSleep = 1'b0;
    payloadPowerOn = 1'b1;
    cnt = 8'h00;
  end
  always @(posedge clk_sys) begin
    cnt <= #1 powerButtonReq ? cnt + 8'h01 : 8'h00;
    if (powerButtonReq && sleepDelay != 8'h00 && cnt == sleepDelay)
      payloadSleep <= #1 1'b1;
    if (forcePowerOff || payloadSleep)
      payloadPowerOn <= #1 1'b0;
    if (powerUp) begin
      payloadSleep <= #1 1'b0;
      payloadPowerOn <= #1 1'b1;
    end
  end
endmodule // mrss_payload_model

// *** mrss_seq_bench.sv ***
// Purpose: self-checking bench for the sequencer
// Assumes: short shutdown and long-press counts
// Notes:   random boot watchdog timeout, sleep delay and short press length
`timescale 1ns/1ps
module mrss_seq_bench;
  import mrss_pkg::*;
  localparam longint unsigned SD = 100;
  localparam longint unsigned LP = 20;
  logic        clk_sys = 1'b0;
  logic        resetn;
  logic        clkEn = 1'b1;
  logic        handleOpen, shutdownCmd, bootRunning, bootWdogKick;
  logic        bootWdogDisable, fwWdogKick, intWdogExpire, resetButton;
  logic        warmResetCmd, powerUp, payloadSleep, payloadPowerOn;
  logic        powerButtonReq, forcePowerOff, bootFlashSel;
  logic        mgmtBusIsolate, consoleNetPower;
  logic [31:0] bootWdogTimeout, fwWdogTimeout;
  logic [7:0]  sleepDelay;
  mrss_rst_s   rstOut;
  int          bad_count = 0, samples_checked = 0, seed = 32'hd50c_acfe;
  int          i, n, k;
  mrss_seq #(.SHUTDOWN_CYCLES(SD), .LONGPRESS_CYCLES(LP)) uut (.clk_sys,
    .resetn, .clkEn, .handleOpen, .shutdownCmd, .payloadSleep,
    .payloadPowerOn, .powerButtonReq, .forcePowerOff, .bootRunning,
    .bootWdogKick, .bootWdogDisable, .bootWdogTimeout, .bootFlashSel,
    .fwWdogKick, .fwWdogTimeout, .intWdogExpire, .mgmtBusIsolate,
    .resetButton, .warmResetCmd, .rstOut, .consoleNetPower);
  mrss_payload_model payload (.clk_sys, .powerButtonReq, .forcePowerOff,
    .powerUp, .sleepDelay, .payloadSleep, .payloadPowerOn);
  always #2.5 clk_sys = ~clk_sys;
  task step(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic isShort(input int len);
    return len < LP;
  endfunction
  task stop_test;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #(5 * 20000);
    bad_count++;
    stop_test;
  end
  initial begin
    {handleOpen, shutdownCmd, bootRunning, bootWdogKick, bootWdogDisable,
     fwWdogKick, intWdogExpire, resetButton, warmResetCmd, powerUp} = '0;
    bootWdogTimeout = 32'hffff_ffff;
    fwWdogTimeout = 32'h0000_0020;
    sleepDelay = 8'(3 + $unsigned($random(seed)) % 18);
    resetn = 1'b0;
    step(2);
    chk(rstOut, 3'h4);
    chk(bootFlashSel, 0);
    resetn = 1'b1;
    step(1);
    chk(rstOut.ctrlCold, 1);
    chk(consoleNetPower, 1);
    step(20);
    $display("reset test done");
    shutdownCmd = 1'b1;
    step(1);
    shutdownCmd = 1'b0;
    chk(powerButtonReq, 1);
    for (i = 0; i < 40 && !payloadSleep; i++) step(1);
    step(2);
    chk({powerButtonReq, forcePowerOff}, 0);
    step(SD + 10);
    chk(forcePowerOff, 0);
    powerUp = 1'b1;
    step(1);
    powerUp = 1'b0;
    step(3);
    chk(rstOut.payloadCold, 1);
    $display("graceful test done");
    sleepDelay = 8'h00;
    handleOpen = 1'b1;
    step(1);
    chk(consoleNetPower, 0);
    chk(powerButtonReq, 1);
    for (n = 0; powerButtonReq && n < SD + 20; n++) step(1);
    chk(forcePowerOff, 1);
    chk(n >= SD - 2 && n <= SD + 1, 1);
    step(3);
    chk(forcePowerOff, 0);
    handleOpen = 1'b0;
    powerUp = 1'b1;
    step(1);
    powerUp = 1'b0;
    $display("timeout test done");
    n = 16 + $unsigned($random(seed)) % 32;
    bootWdogTimeout = n;
    bootRunning = 1'b1;
    bootWdogKick = 1'b1;
    step(1);
    bootWdogKick = 1'b0;
    for (i = 0; i < n + 10 && !bootFlashSel; i++) step(1);
    chk(bootFlashSel, 1);
    step(2);
    chk(rstOut.payloadCold, 1);
    bootWdogDisable = 1'b1;
    step(n + 20);
    chk(bootFlashSel, 1);
    bootRunning = 1'b0;
    bootWdogDisable = 1'b0;
    step(n + 20);
    chk(bootFlashSel, 1);
    bootWdogDisable = 1'b1;
    $display("boot test done");
    intWdogExpire = 1'b1;
    step(1);
    intWdogExpire = 1'b0;
    step(1);
    chk(rstOut.ctrlCold, 1);
    step(20);
    warmResetCmd = 1'b1;
    step(1);
    warmResetCmd = 1'b0;
    step(1);
    chk(rstOut.ctrlWarm, 1);
    chk(bootFlashSel, 1);
    step(20);
    for (k = 0; k < 2; k++) begin
      n = k ? LP + 5 : 2 + $unsigned($random(seed)) % (LP - 6);
      resetButton = 1'b1;
      step(n);
      resetButton = 1'b0;
      step(3);
      chk(rstOut.payloadCold, isShort(n));
      chk(rstOut.ctrlCold, !isShort(n));
      step(20);
    end
    $display("reset source test done");
    fwWdogKick = 1'b1;
    step(1);
    fwWdogKick = 1'b0;
    for (i = 0; i < 60 && !mgmtBusIsolate; i++) step(1);
    step(1);
    chk({mgmtBusIsolate, rstOut.ctrlCold}, 3);
    chk({rstOut.payloadCold, payloadPowerOn}, 1);
    resetn = 1'b0;
    step(1);
    chk({rstOut, mgmtBusIsolate, bootFlashSel}, 5'h10);
    resetn = 1'b1;
    step(1);
    chk(rstOut.ctrlCold, 1);
    $display("watchdog test done");
    stop_test;
  end
endmodule // mrss_seq_bench
bind mrss_seq mrss_seq_checker #(.SHUTDOWN_CYCLES(SHUTDOWN_CYCLES),
  .LONGPRESS_CYCLES(LONGPRESS_CYCLES)) checker_i (.clk_sys, .resetn,
  .handleOpen, .shutdownCmd, .payloadSleep, .powerButtonReq, .forcePowerOff,
  .consoleNetPower, .bootFlashSel, .intWdogExpire, .mgmtBusIsolate,
  .resetButton, .rstOut);
